// *** rtl/limit_monitor_pkg.sv ***
package limit_monitor_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_FLAGS     = 8'h01;
  localparam logic [7:0] ADDR_MASK      = 8'h03;
  localparam logic [7:0] ADDR_READ_BASE = 8'h20;
  localparam logic [7:0] ADDR_TEMP_READ = 8'h27;
  localparam logic [7:0] ADDR_LIM_BASE  = 8'h2A;
  localparam logic [7:0] ADDR_LIM_LAST  = 8'h37;
  localparam logic [7:0] ADDR_TEMP_HIGH = 8'h38;
  localparam logic [7:0] ADDR_TEMP_REL  = 8'h39;
  localparam logic [7:0] ADDR_MAKER     = 8'h3E;
  localparam logic [7:0] ADDR_REVISION  = 8'h3F;

  // control field positions
  localparam int CTRL_START  = 0;
  localparam int CTRL_INT_EN = 1;
  localparam int CTRL_CLEAR  = 3;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h08;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // identification codes: values are arbitrary
  localparam logic [7:0] MAKER_CODE    = 8'h5A;
  localparam logic [7:0] REVISION_CODE = 8'hA3;

  // channel layout: seven voltage channels, temperature last
  localparam int                VOLT_CHANNELS = 7;
  localparam logic [2:0]        TEMP_CHANNEL  = 3'h7;
  localparam int                LIMIT_COUNT   = 14;
  localparam logic signed [13:0] VOLT_FULL    = 14'sh0FFF;

  // two-wire target address
  localparam logic [6:0] TARGET_ADDR = 7'h1D;

  // byte-level events from the serial target
  typedef struct packed {
    logic       start;
    logic       wr;
    logic       first;
    logic       rd;
    logic [7:0] data;
  } link_evt_s;

endpackage

// *** rtl/two_wire_target.sv ***
`timescale 1ns/1ps

module two_wire_target (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        scl,
  input  wire logic                        sdaIn,
  output logic                             sdaOut,
  output logic                             sdaOe,
  input  wire logic [7:0]                  rdByte,
  output limit_monitor_pkg::link_evt_s     evt
);

  typedef enum logic [2:0] {IDLE, ADDR, ACK_A, WRITE, ACK_W, READ, ACK_R} tw_state_e;

  tw_state_e  state_reg;
  logic       sclPrev_reg;
  logic       sdaPrev_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic       rnw_reg;
  logic       first_reg;
  logic       acked_reg;
  logic       startCond;
  logic       stopCond;
  logic       sclRise;
  logic       sclFall;

  // line edges, both lines taken as synchronous
  assign startCond = scl && sclPrev_reg && sdaPrev_reg && !sdaIn;
  assign stopCond  = scl && sclPrev_reg && !sdaPrev_reg && sdaIn;
  assign sclRise   = scl && !sclPrev_reg;
  assign sclFall   = !scl && sclPrev_reg;
  assign sdaOut    = 1'b0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= scl;
      sdaPrev_reg <= sdaIn;
    end
  end

  // byte engine; only drives low, so the line stays open-drain
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg  <= 8'h00;
      tx_reg     <= 8'h00;
      rnw_reg    <= 1'b0;
      first_reg  <= 1'b0;
      acked_reg  <= 1'b0;
      sdaOe      <= 1'b0;
      evt        <= '0;
    end else begin
      evt <= '0;
      if (startCond) begin
        state_reg  <= ADDR;
        bitCnt_reg <= 4'h0;
        sdaOe      <= 1'b0;
        evt.start  <= 1'b1;
      end else if (stopCond) begin
        state_reg <= IDLE;
        sdaOe     <= 1'b0;
      end else if (sclRise) begin
        if (state_reg == ADDR || state_reg == WRITE) begin
          shift_reg  <= {shift_reg[6:0], sdaIn};
          bitCnt_reg <= bitCnt_reg + 4'h1;
        end
        if (state_reg == ACK_R) begin
          acked_reg <= !sdaIn;
        end
      end else if (sclFall) begin
        case (state_reg)
          ADDR: begin
            if (bitCnt_reg == 4'h8) begin
              bitCnt_reg <= 4'h0;
              if (shift_reg[7:1] == limit_monitor_pkg::TARGET_ADDR) begin
                state_reg <= ACK_A;
                rnw_reg   <= shift_reg[0];
                sdaOe     <= 1'b1;
              end else begin
                state_reg <= IDLE;
              end
            end
          end
          ACK_A, ACK_R: begin
            if (rnw_reg && (state_reg == ACK_A || acked_reg)) begin
              tx_reg     <= rdByte;
              sdaOe      <= !rdByte[7];
              bitCnt_reg <= 4'h1;
              state_reg  <= READ;
              evt.rd     <= 1'b1;
            end else if (!rnw_reg) begin
              sdaOe     <= 1'b0;
              first_reg <= 1'b1;
              state_reg <= WRITE;
            end else begin
              sdaOe     <= 1'b0;
              state_reg <= IDLE;
            end
          end
          WRITE: begin
            if (bitCnt_reg == 4'h8) begin
              bitCnt_reg <= 4'h0;
              evt.wr     <= 1'b1;
              evt.first  <= first_reg;
              evt.data   <= shift_reg;
              first_reg  <= 1'b0;
              sdaOe      <= 1'b1;
              state_reg  <= ACK_W;
            end
          end
          ACK_W: begin
            sdaOe     <= 1'b0;
            state_reg <= WRITE;
          end
          READ: begin
            if (bitCnt_reg == 4'h8) begin
              sdaOe     <= 1'b0;
              state_reg <= ACK_R;
            end else begin
              sdaOe      <= !tx_reg[6];
              tx_reg     <= {tx_reg[6:0], 1'b0};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
          end
          default: state_reg <= IDLE;
        endcase
      end
    end
  end

endmodule

// *** rtl/limit_monitor_interrupt.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - maker identification byte is fixed and ignores writes.
// - silicon revision byte is fixed and never changes.
// - voltage codes are 12-bit, clamped to zero and to full scale.
// - temperature result is 9-bit two's complement, half a degree per step.
// - temperature result is held in 9 bits and read left aligned in a 16-bit word, as two bytes.
// - temperature limits are 8-bit two's complement, one degree per step.
// - temperature flag raised when reading strictly exceeds the high threshold.
// - every voltage channel is window checked; the temperature channel uses high and release thresholds.
// - voltage violation: reading above high limit, or at or below low limit.
// - pin asserts only with clear bit low, enable high and a violation.
// - reading the flag register returns it and then clears the bits it returned.
// - cleared flags leave the pin inactive until the loop sets a flag again.
// - writing one to the clear bit deasserts the pin.
// - while the clear bit is one the channel loop is halted.
// - temperature flag holds until a flag read or the clear bit.
// - once cleared, temperature flag returns at next temperature result.
// - recurs until reading at or below release and a flag read happened.
// - mask bits block flags from the pin but flags still record.
// - after reset start bit reads zero and clear bit reads one.
// - flag register holds one bit per monitored limit source.
module limit_monitor_interrupt (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  scl,
  input  wire logic                  sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOe,
  output logic                       intOut,
  output logic                       intOe,
  output logic                       convStart,
  output logic [2:0]                 convChan,
  input  wire logic                  convDone,
  input  wire logic signed [13:0]    convRaw
);

  typedef enum logic {LOOP_IDLE, LOOP_WAIT} loop_state_e;

  limit_monitor_pkg::link_evt_s evt;
  loop_state_e  loop_reg;
  logic [7:0]   ctrl_reg;
  logic [7:0]   mask_reg;
  logic [7:0]   flags_reg;
  logic [7:0]   flags_next;
  logic [7:0]   flagsSeen_reg;
  logic [7:0]   ptr_reg;
  logic         byteSel_reg;
  logic [7:0]   limit_reg [0:limit_monitor_pkg::LIMIT_COUNT-1];
  logic [7:0]   tempHigh_reg;
  logic [7:0]   tempRel_reg;
  logic [11:0]  volt_reg [0:limit_monitor_pkg::VOLT_CHANNELS-1];
  logic [8:0]   temp_reg;
  logic [2:0]   chan_reg;
  logic         hot_reg;
  logic         readSinceHot_reg;
  logic         intActive_reg;
  logic [7:0]   rdByte;
  logic [15:0]  wide;
  logic         done;
  logic         isTemp;
  logic [11:0]  voltCode;
  logic [8:0]   tempCode;
  logic         voltViol;
  logic         tempOver;
  logic         tempBelowRel;
  logic         flagRead;
  logic         halted;
  logic         pinCond;

  // clamp raw converter value into the 12-bit code range
  function automatic logic [11:0] saturate(input logic signed [13:0] raw);
    if (raw < 14'sh0000) begin
      return 12'h000;
    end else if (raw > limit_monitor_pkg::VOLT_FULL) begin
      return 12'hFFF;
    end
    return raw[11:0];
  endfunction

  // one-degree limit to half-degree steps for a signed compare
  function automatic logic signed [8:0] degToHalf(input logic [7:0] lim);
    return $signed({lim, 1'b0});
  endfunction

  two_wire_target u_link (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .scl     (scl),
    .sdaIn   (sdaIn),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe),
    .rdByte  (rdByte),
    .evt     (evt)
  );

  // conversion result decode and window checks
  assign done         = convDone && (loop_reg == LOOP_WAIT);
  assign isTemp       = (chan_reg == limit_monitor_pkg::TEMP_CHANNEL);
  assign voltCode     = saturate(convRaw);
  assign tempCode     = convRaw[8:0];
  assign voltViol     = (voltCode[11:4] > limit_reg[{chan_reg, 1'b0}])
                     || (voltCode[11:4] <= limit_reg[{chan_reg, 1'b1}]);
  assign tempOver     = $signed(tempCode) > degToHalf(tempHigh_reg);
  assign tempBelowRel = $signed(tempCode) <= degToHalf(tempRel_reg);
  assign flagRead     = evt.rd && (ptr_reg == limit_monitor_pkg::ADDR_FLAGS);
  assign halted       = !ctrl_reg[limit_monitor_pkg::CTRL_START]
                     || ctrl_reg[limit_monitor_pkg::CTRL_CLEAR];

  // read mux; 16-bit readings are left aligned, high byte first
  always_comb begin
    wide   = 16'h0000;
    rdByte = 8'h00;
    if (ptr_reg == limit_monitor_pkg::ADDR_CTRL) begin
      rdByte = ctrl_reg;
    end else if (ptr_reg == limit_monitor_pkg::ADDR_FLAGS) begin
      rdByte = flags_reg;
    end else if (ptr_reg == limit_monitor_pkg::ADDR_MASK) begin
      rdByte = mask_reg;
    end else if (ptr_reg == limit_monitor_pkg::ADDR_TEMP_READ) begin
      wide   = {temp_reg, 7'h00};
      rdByte = byteSel_reg ? wide[7:0] : wide[15:8];
    end else if (ptr_reg >= limit_monitor_pkg::ADDR_READ_BASE
              && ptr_reg < limit_monitor_pkg::ADDR_TEMP_READ) begin
      wide   = {volt_reg[3'(ptr_reg - limit_monitor_pkg::ADDR_READ_BASE)], 4'h0};
      rdByte = byteSel_reg ? wide[7:0] : wide[15:8];
    end else if (ptr_reg >= limit_monitor_pkg::ADDR_LIM_BASE
              && ptr_reg <= limit_monitor_pkg::ADDR_LIM_LAST) begin
      rdByte = limit_reg[4'(ptr_reg - limit_monitor_pkg::ADDR_LIM_BASE)];
    end else if (ptr_reg == limit_monitor_pkg::ADDR_TEMP_HIGH) begin
      rdByte = tempHigh_reg;
    end else if (ptr_reg == limit_monitor_pkg::ADDR_TEMP_REL) begin
      rdByte = tempRel_reg;
    end else if (ptr_reg == limit_monitor_pkg::ADDR_MAKER) begin
      rdByte = limit_monitor_pkg::MAKER_CODE;
    end else if (ptr_reg == limit_monitor_pkg::ADDR_REVISION) begin
      rdByte = limit_monitor_pkg::REVISION_CODE;
    end
  end

  // register pointer; wide readings step after their low byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg     <= 8'h00;
      byteSel_reg <= 1'b0;
    end else if (evt.start) begin
      byteSel_reg <= 1'b0;
    end else if (evt.wr) begin
      byteSel_reg <= 1'b0;
      ptr_reg     <= evt.first ? evt.data : ptr_reg + 8'h01;
    end else if (evt.rd) begin
      if (ptr_reg >= limit_monitor_pkg::ADDR_READ_BASE
          && ptr_reg <= limit_monitor_pkg::ADDR_TEMP_READ && !byteSel_reg) begin
        byteSel_reg <= 1'b1;
      end else begin
        byteSel_reg <= 1'b0;
        ptr_reg     <= ptr_reg + 8'h01;
      end
    end
  end

  // writable registers; identification bytes have no storage to write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= limit_monitor_pkg::CTRL_RESET;
      mask_reg     <= limit_monitor_pkg::MASK_RESET;
      tempHigh_reg <= 8'h00;
      tempRel_reg  <= 8'h00;
      for (int i = 0; i < limit_monitor_pkg::LIMIT_COUNT; i++) begin
        limit_reg[i] <= 8'h00;
      end
    end else if (evt.wr && !evt.first) begin
      if (ptr_reg == limit_monitor_pkg::ADDR_CTRL) begin
        ctrl_reg <= evt.data;
      end else if (ptr_reg == limit_monitor_pkg::ADDR_MASK) begin
        mask_reg <= evt.data;
      end else if (ptr_reg >= limit_monitor_pkg::ADDR_LIM_BASE
                && ptr_reg <= limit_monitor_pkg::ADDR_LIM_LAST) begin
        limit_reg[4'(ptr_reg - limit_monitor_pkg::ADDR_LIM_BASE)] <= evt.data;
      end else if (ptr_reg == limit_monitor_pkg::ADDR_TEMP_HIGH) begin
        tempHigh_reg <= evt.data;
      end else if (ptr_reg == limit_monitor_pkg::ADDR_TEMP_REL) begin
        tempRel_reg <= evt.data;
      end
    end
  end

  // round-robin loop; a pending result is still taken after a halt
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_reg <= LOOP_IDLE;
      chan_reg <= 3'h0;
    end else begin
      case (loop_reg)
        LOOP_IDLE: begin
          if (!halted) begin
            loop_reg <= LOOP_WAIT;
          end
        end
        LOOP_WAIT: begin
          if (convDone) begin
            loop_reg <= LOOP_IDLE;
            chan_reg <= chan_reg + 3'h1;
          end
        end
        default: loop_reg <= LOOP_IDLE;
      endcase
    end
  end

  assign convStart = (loop_reg == LOOP_IDLE) && !halted;
  assign convChan  = chan_reg;

  // reading storage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_reg <= 9'h000;
      for (int i = 0; i < limit_monitor_pkg::VOLT_CHANNELS; i++) begin
        volt_reg[i] <= 12'h000;
      end
    end else if (done) begin
      if (isTemp) begin
        temp_reg <= tempCode;
      end else begin
        volt_reg[chan_reg] <= voltCode;
      end
    end
  end

  // hot latch: released only when cool and a flag read has happened
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hot_reg          <= 1'b0;
      readSinceHot_reg <= 1'b0;
    end else begin
      if (done && isTemp && tempOver) begin
        hot_reg          <= 1'b1;
        readSinceHot_reg <= 1'b0;
      end else if (done && isTemp && tempBelowRel && readSinceHot_reg) begin
        hot_reg <= 1'b0;
      end else if (flagRead && hot_reg) begin
        readSinceHot_reg <= 1'b1;
      end
    end
  end

  // flag register; a new event in the clearing cycle survives
  always_comb begin
    flags_next = flags_reg;
    if (ctrl_reg[limit_monitor_pkg::CTRL_CLEAR]) begin
      flags_next = 8'h00;
    end else if (flagRead) begin
      flags_next = flags_reg & ~flagsSeen_reg;
    end
    if (done) begin
      if (isTemp) begin
        if (tempOver || (hot_reg && !(tempBelowRel && readSinceHot_reg))) begin
          flags_next[limit_monitor_pkg::TEMP_CHANNEL] = 1'b1;
        end
      end else if (voltViol) begin
        flags_next[chan_reg] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg     <= 8'h00;
      flagsSeen_reg <= 8'h00;
    end else begin
      flags_reg     <= flags_next;
      // byte the link latched one edge before the read strobe; a flag set
      // on that edge was never shown to the host, so the read keeps it
      flagsSeen_reg <= flags_reg;
    end
  end

  // pin drive: active low, open drain
  assign pinCond = !ctrl_reg[limit_monitor_pkg::CTRL_CLEAR]
                && ctrl_reg[limit_monitor_pkg::CTRL_INT_EN]
                && |(flags_reg & ~mask_reg);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      intActive_reg <= 1'b0;
    end else begin
      intActive_reg <= pinCond;
    end
  end

  assign intOut = 1'b0;
  assign intOe  = intActive_reg;

  property p_clear_drops_pin;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_reg[limit_monitor_pkg::CTRL_CLEAR] |=> !intOe;
  endproperty
  a_clear_drops_pin: assert property (p_clear_drops_pin)
    else $error("pin active while clear bit set");

  property p_pin_cause;
    @(posedge sys_clk) disable iff (!rst_n)
      intOe |-> $past(ctrl_reg[limit_monitor_pkg::CTRL_INT_EN])
             && !$past(ctrl_reg[limit_monitor_pkg::CTRL_CLEAR])
             && ($past(flags_reg & ~mask_reg) != 8'h00);
  endproperty
  a_pin_cause: assert property (p_pin_cause)
    else $error("pin active without its three conditions");

  property p_read_clears;
    @(posedge sys_clk) disable iff (!rst_n)
      flagRead && !done && !ctrl_reg[limit_monitor_pkg::CTRL_CLEAR]
        |=> flags_reg == ($past(flags_reg) & ~$past(flagsSeen_reg));
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("flag read did not clear flags");

  property p_halt;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_reg[limit_monitor_pkg::CTRL_CLEAR] && loop_reg == LOOP_IDLE
        |-> !convStart ##1 loop_reg == LOOP_IDLE;
  endproperty
  a_halt: assert property (p_halt)
    else $error("conversion started while halted");

  property p_volt_flag;
    @(posedge sys_clk) disable iff (!rst_n)
      done && !isTemp && voltViol ##1 !$past(ctrl_reg[limit_monitor_pkg::CTRL_CLEAR])
        |-> flags_reg[$past(chan_reg)];
  endproperty
  a_volt_flag: assert property (p_volt_flag)
    else $error("voltage violation not flagged");

  property p_temp_flag;
    @(posedge sys_clk) disable iff (!rst_n)
      done && isTemp && tempOver |=> flags_reg[limit_monitor_pkg::TEMP_CHANNEL] && hot_reg;
  endproperty
  a_temp_flag: assert property (p_temp_flag)
    else $error("temperature over threshold not flagged");

  property p_mask;
    @(posedge sys_clk) disable iff (!rst_n)
      (flags_reg & ~mask_reg) == 8'h00 |=> !intOe;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked flag reached the pin");

  property p_ident;
    @(posedge sys_clk) disable iff (!rst_n)
      ptr_reg == limit_monitor_pkg::ADDR_MAKER |-> rdByte == limit_monitor_pkg::MAKER_CODE;
  endproperty
  a_ident: assert property (p_ident)
    else $error("maker byte changed");

  property p_saturate;
    @(posedge sys_clk) disable iff (!rst_n)
      done && !isTemp && convRaw < 14'sh0000 |=> volt_reg[$past(chan_reg)] == 12'h000;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("negative input not clamped to zero");

endmodule

// *** tb/two_wire_host.sv ***
`timescale 1ns/1ps

module two_wire_host (
  input  wire logic sys_clk,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaLow
);
  logic ackLine;
  int   nacks;

  // bus idles released: clock high and standing still, data pulled up
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
    nacks  = 0;
  end

  // four system clocks per half bit, above the two the block needs
  task automatic half();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // data moves only while the clock is low, so no false start or stop
  task automatic sendBit(input logic b, output logic got);
    sdaLow = ~b;
    half();
    scl = 1'b1;
    half();
    got = sdaLine;
    scl = 1'b0;
    half();
  endtask

  // start and repeated start alike
  task automatic startBit();
    sdaLow = 1'b0;
    half();
    scl = 1'b1;
    half();
    sdaLow = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask

  task automatic stopBit();
    sdaLow = 1'b1;
    half();
    scl = 1'b1;
    half();
    sdaLow = 1'b0;
    half();
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ackBit, output logic [7:0] rx);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      sendBit(tx[i], b);
      rx[i] = b;
    end
    sendBit(ackBit, b);
    ackLine = b;
  endtask

  task automatic writeReg(input logic [7:0] ptr, input logic [7:0] data);
    logic [7:0] rx;
    startBit();
    xfer({limit_monitor_pkg::TARGET_ADDR, 1'b0}, 1'b1, rx);
    nacks += int'(ackLine);
    xfer(ptr, 1'b1, rx);
    nacks += int'(ackLine);
    xfer(data, 1'b1, rx);
    nacks += int'(ackLine);
    stopBit();
  endtask

  // two-byte reads ack the high byte and nack the low one
  task automatic readReg(input logic [7:0] ptr, input int n, output logic [15:0] v);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = 8'h00;
    startBit();
    xfer({limit_monitor_pkg::TARGET_ADDR, 1'b0}, 1'b1, lo);
    nacks += int'(ackLine);
    xfer(ptr, 1'b1, lo);
    nacks += int'(ackLine);
    startBit();
    xfer({limit_monitor_pkg::TARGET_ADDR, 1'b1}, 1'b1, lo);
    nacks += int'(ackLine);
    if (n == 2) begin
      xfer(8'hFF, 1'b0, hi);
    end
    xfer(8'hFF, 1'b1, lo);
    stopBit();
    v = {hi, lo};
  endtask
endmodule

// *** tb/tb_limit_monitor_interrupt.sv ***
`timescale 1ns/1ps

module tb_limit_monitor_interrupt;
  logic               sys_clk;
  logic               rst_n;
  logic               scl;
  logic               sdaIn;
  logic               sdaOut;
  logic               sdaOe;
  logic               hostSdaLow;
  logic               intOut;
  logic               intOe;
  logic               convStart;
  logic [2:0]         convChan;
  logic               convDone;
  logic signed [13:0] convRaw;
  logic signed [13:0] rawTable [8];
  logic [15:0]        rdVal;
  int                 doneCount;
  int                 snap;
  int                 cycles;
  int                 n_mismatch;
  int                 total_checks;

  // open-drain data line with pull-up
  assign sdaIn = ~(hostSdaLow | sdaOe);

  limit_monitor_interrupt limit_monitor_interrupt_i (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .scl       (scl),
    .sdaIn     (sdaIn),
    .sdaOut    (sdaOut),
    .sdaOe     (sdaOe),
    .intOut    (intOut),
    .intOe     (intOe),
    .convStart (convStart),
    .convChan  (convChan),
    .convDone  (convDone),
    .convRaw   (convRaw)
  );

  two_wire_host two_wire_host_i (
    .sys_clk (sys_clk),
    .sdaLine (sdaIn),
    .scl     (scl),
    .sdaLow  (hostSdaLow)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // converter stand-in; stale result inverted so it is never reused by luck
  initial begin
    convDone  = 1'b0;
    convRaw   = 14'sh0000;
    doneCount = 0;
    forever begin
      @(posedge sys_clk);
      #1;
      while (convStart === 1'b1) begin
        repeat (3) @(posedge sys_clk);
        #1;
        convRaw  = rawTable[convChan];
        convDone = 1'b1;
        @(posedge sys_clk);
        #1;
        convDone = 1'b0;
        convRaw  = ~convRaw;
        doneCount++;
      end
    end
  end

  // hang guard, well above the expected run length
  initial cycles = 0;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chkReg(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkPin(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: pin got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input int n, input logic [15:0] e);
    two_wire_host_i.readReg(a, n, rdVal);
    chkReg(rdVal, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    two_wire_host_i.writeReg(a, d);
  endtask

  // bounded wait for a number of finished conversions
  task automatic waitConv(input int n);
    int target;
    target = doneCount + n;
    for (int i = 0; i < 2000 && doneCount < target; i++) begin
      @(posedge sys_clk);
    end
    #1;
    chkPin(doneCount >= target, 1'b1);
  endtask

  initial begin
    n_mismatch   = 0;
    total_checks = 0;
    // ch0 and ch3 sit on the limit edges without failing
    rawTable = '{14'sh0800, 14'sh0810, 14'sh0100, 14'sh0110,
                 14'sh3FFB, 14'sh1388, 14'sh07F0, 14'sh0033};
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    // reset state and identification bytes
    rdChk(8'h00, 1, 16'h0008);
    rdChk(8'h03, 1, 16'h0000);
    rdChk(8'h01, 1, 16'h0000);
    wr(8'h3E, 8'hFF);
    wr(8'h3F, 8'h00);
    rdChk(8'h3E, 1, {8'h00, limit_monitor_pkg::MAKER_CODE});
    rdChk(8'h3F, 1, {8'h00, limit_monitor_pkg::REVISION_CODE});
    chkPin(convStart, 1'b0);
    chkPin(intOe, 1'b0);
    // window limits for every voltage channel, 25 and 24 degrees for temperature
    for (int n = 0; n < 7; n++) begin
      wr(8'h2A + 8'(2 * n), 8'h80);
      wr(8'h2B + 8'(2 * n), 8'h10);
    end
    wr(8'h38, 8'h19);
    wr(8'h39, 8'h18);
    wr(8'h00, 8'h03);
    waitConv(16);
    chkPin(intOe, 1'b1);
    rdChk(8'h01, 1, 16'h00B6);
    rdChk(8'h21, 2, 16'h8100);
    rdChk(8'h24, 2, 16'h0000);
    rdChk(8'h25, 2, 16'hFFF0);
    rdChk(8'h27, 2, 16'h1980);
    waitConv(16);
    rdChk(8'h01, 1, 16'h00B6);
    // stopped loop: a read empties the flags and frees the pin
    wr(8'h00, 8'h02);
    repeat (50) @(posedge sys_clk);
    two_wire_host_i.readReg(8'h01, 1, rdVal);
    rdChk(8'h01, 1, 16'h0000);
    chkPin(intOe, 1'b0);
    // clear bit drops the pin and halts the loop
    wr(8'h00, 8'h03);
    waitConv(16);
    chkPin(intOe, 1'b1);
    wr(8'h00, 8'h0B);
    chkPin(intOe, 1'b0);
    snap = doneCount;
    repeat (100) @(posedge sys_clk);
    #1;
    chkReg(16'(doneCount - snap), 16'h0000);
    chkPin(convStart, 1'b0);
    rdChk(8'h01, 1, 16'h0000);
    // masked sources still record but leave the pin alone
    wr(8'h03, 8'hB6);
    rdChk(8'h03, 1, 16'h00B6);
    wr(8'h00, 8'h03);
    waitConv(16);
    chkPin(intOe, 1'b0);
    rdChk(8'h01, 1, 16'h00B6);
    // enable low keeps the pin off
    wr(8'h03, 8'h00);
    wr(8'h00, 8'h01);
    waitConv(16);
    chkPin(intOe, 1'b0);
    // every host-sent byte must have been acknowledged by the target
    chkReg(16'(two_wire_host_i.nacks), 16'h0000);
    chkPin(intOut, 1'b0);
    chkPin(sdaOut, 1'b0);
    end_of_test();
  end
endmodule
